// [hw/i2cs_params.svh]
// Constants for the scripted I2C master sequencer
// Notes on behaviour
// - A stop command drives a stop condition onto the bus of the port chosen at launch only when a start holds that bus; otherwise it does nothing.
// - A read clocks in exactly the programmed byte count and acknowledges every byte before the final one.
// - The final read byte is not acknowledged when the no-acknowledge option is set, and acknowledged otherwise.
// - Every received byte leaves tagged with the index of the read command that fetched it.
// - A write shifts out every byte of its array in array order.
// - After each written byte the slave acknowledge bit is sampled before going on.
// - A no-acknowledge on a written byte stops the script and reports an error.
// - Every stop, read and write acts on the port selected when the script is launched.
// - A start on a bus not already held waits for a free bus and reports an error if it is still busy after one second; a repeated start does not wait.
`ifndef I2CS_PARAMS_SVH
`define I2CS_PARAMS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define I2CS_NPORT         2
`define I2CS_PORT_W        1
`define I2CS_FIFO_DEPTH    8
// ----------------------------------------
// Timing
// ----------------------------------------
`define I2CS_CLK_PERIOD_NS 20
`define I2CS_QTR_NS        2500
`define I2CS_QTR_CYC       (`I2CS_QTR_NS / `I2CS_CLK_PERIOD_NS)
`define I2CS_FREE_TMO_S    1
`define I2CS_FREE_TMO_CYC  ((`I2CS_FREE_TMO_S * 1000000000) / `I2CS_CLK_PERIOD_NS)
// ----------------------------------------
// Bit slot phases and positions
// ----------------------------------------
`define I2CS_PH_LOW        2'h0
`define I2CS_PH_HIGH       2'h1
`define I2CS_PH_HOLD       2'h2
`define I2CS_PH_LAST       2'h3
`define I2CS_ACK_BIT       4'h8
`define I2CS_MSB           7
`endif

// [hw/i2cs_pkg.sv]
// Types shared by the scripted I2C master sequencer
package i2cs_pkg;
    typedef enum logic [1:0] {
        I2CS_OP_START = 2'h0,
        I2CS_OP_STOP  = 2'h1,
        I2CS_OP_READ  = 2'h2,
        I2CS_OP_WRITE = 2'h3
    } i2cs_op_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_FETCH = 3'h1,
        S_FREE  = 3'h2,
        S_START = 3'h3,
        S_STOP  = 3'h4,
        S_BYTE  = 3'h5,
        S_SKIP  = 3'h6,
        S_DONE  = 3'h7
    } i2cs_state_t;

    typedef struct packed {
        i2cs_op_t   op;
        logic       last_cmd;
        logic       arr_last;
        logic       nak_last;
        logic [7:0] read_byte_count;
        logic [7:0] wdata;
    } i2cs_cmd_t;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
        logic       last;
    } i2cs_rdata_t;

    typedef struct packed {
        logic       error;
        logic       timeout;
        logic [7:0] cmd_index;
    } i2cs_status_t;
endpackage

// [hw/i2cs_master.sv]
// Scripted I2C master: command FIFO and bus sequencer
`timescale 1ns/1ps
`include "i2cs_params.svh"

// ----------------------------------------
// Command FIFO
// ----------------------------------------
module i2cs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    // Fill side
    input  wire logic         s_valid,
    output logic              s_ready,
    input  wire logic [W-1:0] s_data,
    // Drain side
    output logic              m_valid,
    input  wire logic         m_ready,
    output logic [W-1:0]      m_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic [AW:0]  next_wp;
    logic [AW:0]  next_rp;
    logic         push;

    always_comb begin
        s_ready = (wp - rp) != (AW+1)'(DEPTH);
        m_valid = wp != rp;
        m_data  = mem[rp[AW-1:0]];
        push    = s_valid && s_ready;
        next_wp = wp + (AW+1)'(push);
        next_rp = rp + (AW+1)'(m_valid && m_ready);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // Storage has no reset; empty slots are never read out
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= s_data;
        end
    end
endmodule

// ----------------------------------------
// Sequencer
// ----------------------------------------
module i2cs_master import i2cs_pkg::*; #(
    parameter int TMO_CYC = `I2CS_FREE_TMO_CYC
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // Script launch and status
    input  wire logic                   run_start,
    input  wire logic [`I2CS_PORT_W-1:0] run_port,
    output logic                        busy,
    output logic                        done,
    output i2cs_status_t                status,
    // Command stream
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    input  wire i2cs_cmd_t              cmd,
    // Read data
    output logic                        rd_valid,
    output i2cs_rdata_t                 rd_out,
    // Bus pins, open drain
    input  wire logic [`I2CS_NPORT-1:0] scl_in,
    output logic [`I2CS_NPORT-1:0]      scl_out,
    output logic [`I2CS_NPORT-1:0]      scl_oe,
    input  wire logic [`I2CS_NPORT-1:0] sda_in,
    output logic [`I2CS_NPORT-1:0]      sda_out,
    output logic [`I2CS_NPORT-1:0]      sda_oe
);
    i2cs_state_t            state, next_state;
    logic [`I2CS_PORT_W-1:0] sel, next_sel;
    logic [31:0]            tmr, next_tmr;
    logic [1:0]             ph, next_ph;
    logic [3:0]             bitn, next_bitn;
    logic [7:0]             shreg, next_shreg;
    logic [7:0]             left, next_left;
    logic [7:0]             cmd_idx, next_cmd_idx;
    logic [7:0]             rd_idx, next_rd_idx;
    i2cs_cmd_t              cur, next_cur;
    i2cs_rdata_t            next_rd_out;
    logic                   owned, next_owned;
    logic                   scl_low, next_scl_low;
    logic                   sda_low, next_sda_low;
    logic                   err, next_err;
    logic                   tmo, next_tmo;
    logic                   next_done, next_rd_valid;
    logic [`I2CS_NPORT-1:0] scl_m, scl_s, sda_m, sda_s;
    logic                   f_valid, f_pop, qdone, fin, scl_bit, sda_bit;
    i2cs_cmd_t              f_cmd;

    i2cs_fifo #(.W($bits(i2cs_cmd_t)), .DEPTH(`I2CS_FIFO_DEPTH)) u_fifo (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .s_valid (cmd_valid),
        .s_ready (cmd_ready),
        .s_data  (cmd),
        .m_valid (f_valid),
        .m_ready (f_pop),
        .m_data  (f_cmd)
    );

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            scl_m <= '1;
            scl_s <= '1;
            sda_m <= '1;
            sda_s <= '1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end

    // Only the launched port is ever driven; pins only ever pull low
    always_comb begin
        scl_out = '0;
        sda_out = '0;
        scl_oe  = '0;
        sda_oe  = '0;
        scl_oe[sel] = scl_low;
        sda_oe[sel] = sda_low;
        scl_bit = scl_s[sel];
        sda_bit = sda_s[sel];
        busy    = state != S_IDLE;
        status  = '{error: err, timeout: tmo, cmd_index: cmd_idx};
    end

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    // No clock stretching: a slave that holds the clock low is not waited for
    always_comb begin
        next_state = state;   next_sel = sel;     next_tmr = tmr + 32'h1;
        next_ph = ph;         next_bitn = bitn;   next_shreg = shreg;
        next_left = left;     next_cmd_idx = cmd_idx; next_rd_idx = rd_idx;
        next_cur = cur;       next_owned = owned; next_scl_low = scl_low;
        next_sda_low = sda_low; next_err = err;   next_tmo = tmo;
        next_rd_out = rd_out; next_done = 1'b0;   next_rd_valid = 1'b0;
        f_pop = 1'b0;         fin = 1'b0;
        qdone = tmr == 32'(`I2CS_QTR_CYC - 1);
        if (qdone && (state == S_START || state == S_STOP || state == S_BYTE)) begin
            next_tmr = '0;
            next_ph  = ph + 2'h1;
        end
        case (state)
            S_IDLE: begin
                if (run_start) begin
                    next_sel = run_port;
                    // An error leaves the bus released, so no earlier start is still owned
                    next_owned = 1'b0;
                    next_err = 1'b0;
                    next_tmo = 1'b0;
                    next_cmd_idx = '0;
                    next_rd_idx = '0;
                    next_state = S_FETCH;
                end
            end
            S_FETCH: begin
                next_tmr = '0;
                next_ph = `I2CS_PH_LOW;
                next_bitn = '0;
                if (f_valid) begin
                    f_pop = 1'b1;
                    next_cur = f_cmd;
                    case (f_cmd.op)
                        I2CS_OP_START: begin
                            next_sda_low = 1'b0;
                            next_state = owned ? S_START : S_FREE;
                        end
                        I2CS_OP_STOP: begin
                            next_sda_low = owned;
                            if (owned) next_state = S_STOP; else fin = 1'b1;
                        end
                        I2CS_OP_READ: begin
                            next_sda_low = 1'b0;
                            next_left = f_cmd.read_byte_count;
                            if (f_cmd.read_byte_count == 8'h0) begin
                                fin = 1'b1;
                                next_rd_idx = rd_idx + 8'h1;
                            end else begin
                                next_state = S_BYTE;
                            end
                        end
                        default: begin
                            next_shreg = f_cmd.wdata;
                            next_sda_low = !f_cmd.wdata[`I2CS_MSB];
                            next_state = S_BYTE;
                        end
                    endcase
                end
            end
            S_FREE: begin
                if (scl_bit && sda_bit) begin
                    next_tmr = '0;
                    next_state = S_START;
                end else if (tmr == 32'(TMO_CYC - 1)) begin
                    next_err = 1'b1;
                    next_tmo = 1'b1;
                    next_state = cur.last_cmd ? S_DONE : S_SKIP;
                end
            end
            S_START: begin
                if (qdone) begin
                    case (ph)
                        `I2CS_PH_LOW:  next_scl_low = 1'b0;
                        `I2CS_PH_HIGH: next_sda_low = 1'b1;
                        `I2CS_PH_HOLD: next_scl_low = 1'b1;
                        default: begin
                            next_owned = 1'b1;
                            fin = 1'b1;
                        end
                    endcase
                end
            end
            S_STOP: begin
                if (qdone) begin
                    case (ph)
                        `I2CS_PH_LOW:  next_scl_low = 1'b0;
                        `I2CS_PH_HIGH: next_sda_low = 1'b0;
                        `I2CS_PH_HOLD: next_owned = owned;
                        default: begin
                            next_owned = 1'b0;
                            fin = 1'b1;
                        end
                    endcase
                end
            end
            S_BYTE: begin
                if (qdone) begin
                    case (ph)
                        `I2CS_PH_LOW: next_scl_low = 1'b0;
                        `I2CS_PH_HIGH: begin
                            if (cur.op == I2CS_OP_READ && bitn != `I2CS_ACK_BIT) begin
                                next_shreg = {shreg[`I2CS_MSB-1:0], sda_bit};
                            end else if (cur.op == I2CS_OP_WRITE && bitn == `I2CS_ACK_BIT && sda_bit) begin
                                next_err = 1'b1;
                                next_state = cur.last_cmd ? S_DONE : S_SKIP;
                            end
                        end
                        `I2CS_PH_HOLD: next_scl_low = 1'b1;
                        default: begin
                            next_bitn = bitn + 4'h1;
                            next_sda_low = 1'b0;
                            if (cur.op == I2CS_OP_WRITE && bitn != `I2CS_ACK_BIT) begin
                                next_shreg = {shreg[`I2CS_MSB-1:0], 1'b0};
                                if (bitn != 4'(`I2CS_MSB)) next_sda_low = !shreg[`I2CS_MSB-1];
                            end else if (cur.op == I2CS_OP_READ && bitn == 4'(`I2CS_MSB)) begin
                                next_sda_low = !(left == 8'h1 && cur.nak_last);
                            end else if (bitn == `I2CS_ACK_BIT) begin
                                next_bitn = '0;
                                if (cur.op == I2CS_OP_WRITE) begin
                                    if (cur.arr_last) fin = 1'b1; else next_state = S_FETCH;
                                end else begin
                                    next_rd_valid = 1'b1;
                                    next_rd_out = '{index: rd_idx, data: shreg, last: left == 8'h1};
                                    next_left = left - 8'h1;
                                    if (left == 8'h1) begin
                                        fin = 1'b1;
                                        next_rd_idx = rd_idx + 8'h1;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            S_SKIP: begin
                // Bus is left released; queued commands are dropped up to script end
                next_scl_low = 1'b0;
                next_sda_low = 1'b0;
                f_pop = f_valid;
                if (f_valid && f_cmd.last_cmd) next_state = S_DONE;
            end
            S_DONE: begin
                next_done = 1'b1;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
        if (fin) begin
            next_cmd_idx = cmd_idx + 8'h1;
            next_state = next_cur.last_cmd ? S_DONE : S_FETCH;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;  sel <= '0;    tmr <= '0;     ph <= '0;
            bitn <= '0;       shreg <= '0;  left <= '0;    cmd_idx <= '0;
            rd_idx <= '0;     cur <= '0;    owned <= 1'b0; scl_low <= 1'b0;
            sda_low <= 1'b0;  err <= 1'b0;  tmo <= 1'b0;   done <= 1'b0;
            rd_valid <= 1'b0; rd_out <= '0;
        end else begin
            state <= next_state;     sel <= next_sel;     tmr <= next_tmr;
            ph <= next_ph;           bitn <= next_bitn;   shreg <= next_shreg;
            left <= next_left;       cmd_idx <= next_cmd_idx; rd_idx <= next_rd_idx;
            cur <= next_cur;         owned <= next_owned; scl_low <= next_scl_low;
            sda_low <= next_sda_low; err <= next_err;     tmo <= next_tmo;
            done <= next_done;       rd_valid <= next_rd_valid; rd_out <= next_rd_out;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence seq_clk_high;
        !scl_low && $past(!scl_low);
    endsequence
    sequence seq_ack_slot;
        state == S_BYTE && bitn == `I2CS_ACK_BIT && ph == `I2CS_PH_HIGH;
    endsequence

    AST_STOP_ONLY_IN_STOP: assert property (seq_clk_high and $fell(sda_low) |-> $past(state) == S_STOP)
        else $error("data released under high clock outside a stop");
    AST_START_ONLY_IN_START: assert property (seq_clk_high and $rose(sda_low) |-> $past(state) == S_START)
        else $error("data pulled under high clock outside a start");
    AST_READ_ACK: assert property (seq_ack_slot and cur.op == I2CS_OP_READ
        and !(left == 8'h1 && cur.nak_last) |-> sda_low)
        else $error("read byte not acknowledged");
    AST_READ_NAK_LAST: assert property (seq_ack_slot and cur.op == I2CS_OP_READ
        and left == 8'h1 && cur.nak_last |-> !sda_low)
        else $error("last read byte acknowledged despite option");
    AST_READ_TAG: assert property ($rose(state == S_FETCH) && $past(state) == S_BYTE && $past(cur.op) == I2CS_OP_READ
        |-> rd_valid && rd_out.index == rd_idx - 8'h1)
        else $error("read byte tagged with wrong command");
    AST_WRITE_RELEASE: assert property (seq_ack_slot and cur.op == I2CS_OP_WRITE |-> !sda_low)
        else $error("data line driven during slave acknowledge");
    AST_WRITE_NAK_ERR: assert property (seq_ack_slot and cur.op == I2CS_OP_WRITE and qdone and sda_bit
        |=> err && (state == S_SKIP || state == S_DONE) ##1 !$rose(scl_low))
        else $error("write no-acknowledge not reported");
    AST_PORT_ONLY: assert property ((scl_oe | sda_oe) == ((scl_oe | sda_oe) & (`I2CS_NPORT'(1) << sel)))
        else $error("unselected port driven");
    AST_SKIP_QUIET: assert property (state == S_SKIP |=> !scl_low && !sda_low && $stable(cmd_idx))
        else $error("bus activity or index change while skipping");
    AST_FREE_TIMEOUT: assert property (state == S_FREE && tmr == 32'(TMO_CYC - 1) && !(scl_bit && sda_bit)
        |=> err && tmo)
        else $error("busy bus timeout not reported");
    AST_WRITE_ORDER: assert property (state == S_BYTE && cur.op == I2CS_OP_WRITE && bitn < `I2CS_ACK_BIT
        && ph == `I2CS_PH_HIGH |-> sda_low == !shreg[`I2CS_MSB])
        else $error("write bit out of order");
endmodule

// [verification/i2cs_slave_model.sv]
// Behavioural I2C slave standing on one bus port of the scripted master
`timescale 1ns/1ps
module i2cs_slave_model (
    // Bus wires, pulled up
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_pull,
    // Behaviour controls
    input  wire logic       rd_mode,
    input  wire logic [7:0] rd_base,
    input  wire logic [7:0] nak_at
);
    logic [7:0] wr_q[$];
    logic       ack_q[$];
    int         n_stop = 0;
    int         bitn = 0;
    int         nbytes = 0;
    logic       active = 1'b0;
    logic [7:0] shreg = 8'h00;
    logic [7:0] rd_byte;
    assign rd_byte = rd_base + nbytes[7:0];
    initial sda_pull = 1'b0;
    // ----------------------------------------
    // Start and stop detection
    // ----------------------------------------
    always @(negedge sda) if (scl) begin
        bitn = 0;
        nbytes = 0;
        active = 1'b1;
    end
    always @(posedge sda) if (scl) begin
        n_stop++;
        active = 1'b0;
    end
    // ----------------------------------------
    // Bit slots
    // ----------------------------------------
    // Launch only after scl falls, so the line is settled long before the master samples
    always @(negedge scl) begin
        sda_pull = 1'b0;
        if (active && rd_mode && bitn < 8)
            sda_pull = ~rd_byte[7-bitn];
        if (active && !rd_mode && bitn == 8)
            sda_pull = (nbytes != nak_at);
    end
    // A refused byte or a final read without acknowledge leaves the slave silent
    always @(posedge scl) if (active) begin
        if (bitn < 8)
            shreg = {shreg[6:0], sda};
        else if (rd_mode) begin
            ack_q.push_back(sda);
            active = ~sda;
        end else begin
            wr_q.push_back(shreg);
            active = (nbytes != nak_at);
        end
        if (bitn == 8)
            nbytes++;
        bitn = (bitn == 8) ? 0 : bitn + 1;
    end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the scripted I2C master
`timescale 1ns/1ps
module testbench import i2cs_pkg::*; ;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    // Short free-bus timeout keeps the busy-bus case quick
    localparam int TMO = 2000;
    logic         ref_clk;
    logic         resetn;
    logic         run_start;
    logic         run_port;
    logic         cmd_valid;
    logic         hold0;
    logic         rd_mode;
    logic         busy;
    logic         done;
    logic         cmd_ready;
    logic         rd_valid;
    logic         pull;
    logic [1:0]   scl_oe;
    logic [1:0]   sda_oe;
    logic [1:0]   scl_in;
    logic [1:0]   sda_in;
    logic [7:0]   rd_base;
    logic [7:0]   nak_at;
    i2cs_cmd_t    cmd;
    i2cs_status_t status;
    i2cs_rdata_t  rd_out;
    i2cs_rdata_t  rd_q[$];
    int           mismatches = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    int           p0_act = 0;
    assign scl_in = {~scl_oe[1], ~(scl_oe[0] | hold0)};
    assign sda_in = {~(sda_oe[1] | pull), ~sda_oe[0]};
    i2cs_master #(.TMO_CYC(TMO)) u_i2cs_master (.ref_clk(ref_clk), .resetn(resetn), .run_start(run_start),
        .run_port(run_port), .busy(busy), .done(done), .status(status), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd_out(rd_out), .scl_in(scl_in),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe));
    i2cs_slave_model u_i2cs_slave_model (.scl(scl_in[1]), .sda(sda_in[1]), .sda_pull(pull),
        .rd_mode(rd_mode), .rd_base(rd_base), .nak_at(nak_at));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (scl_oe[0] | sda_oe[0])
            p0_act++;
        if (rd_valid)
            rd_q.push_back(rd_out);
        if (cyc == 60000) begin
            mismatches++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Held until taken; valid is dropped by the launch
    task automatic push(input i2cs_op_t op, input logic lst, input logic arr, input logic nak, input logic [7:0] v);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd = '{op, lst, arr, nak, v, v};
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    endtask
    task automatic run(input logic p, input int ncyc);
        int n;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        run_port = p;
        run_start = 1'b1;
        @(negedge ref_clk);
        run_start = 1'b0;
        chk("busy", busy, 1);
        n = 0;
        while (done !== 1'b1 && n < ncyc) begin
            @(negedge ref_clk);
            n++;
        end
        chk("done", done, 1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_fifo_stop();
        int s0;
        s0 = u_i2cs_slave_model.n_stop;
        push(I2CS_OP_START, 0, 0, 0, 8'h00);
        for (int i = 0; i < 7; i++)
            push(I2CS_OP_STOP, i == 6, 0, 0, 8'h00);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        chk("cmd_ready full", cmd_ready, 0);
        run(1'b1, 3000);
        chk("stops", u_i2cs_slave_model.n_stop - s0, 1);
        chk("status", status, {2'b00, 8'h08});
    endtask
    task automatic t_write();
        int s0;
        s0 = u_i2cs_slave_model.n_stop;
        push(I2CS_OP_START, 0, 0, 0, 8'h00);
        push(I2CS_OP_WRITE, 0, 0, 0, 8'ha5);
        push(I2CS_OP_WRITE, 0, 1, 0, 8'h3c);
        push(I2CS_OP_STOP, 1, 0, 0, 8'h00);
        run(1'b1, 12000);
        chk("wr count", u_i2cs_slave_model.wr_q.size(), 2);
        chk("wr byte0", u_i2cs_slave_model.wr_q[0], 8'ha5);
        chk("wr byte1", u_i2cs_slave_model.wr_q[1], 8'h3c);
        chk("stops", u_i2cs_slave_model.n_stop - s0, 1);
        chk("status", status, {2'b00, 8'h03});
    endtask
    task automatic t_read();
        rd_mode = 1'b1;
        rd_q.delete();
        push(I2CS_OP_START, 0, 0, 0, 8'h00);
        push(I2CS_OP_READ, 0, 0, 0, 8'h02);
        push(I2CS_OP_READ, 0, 0, 1, 8'h02);
        push(I2CS_OP_READ, 0, 0, 0, 8'h00);
        push(I2CS_OP_STOP, 1, 0, 0, 8'h00);
        run(1'b1, 22000);
        chk("rd count", rd_q.size(), 4);
        for (int k = 0; k < 4; k++) begin
            chk("rd word", rd_q[k], {8'(k / 2), 8'h50 + 8'(k), k[0]});
            chk("master ack", u_i2cs_slave_model.ack_q[k], k == 3);
        end
        chk("status", status, {2'b00, 8'h05});
        rd_mode = 1'b0;
    endtask
    task automatic t_nak();
        int s0;
        s0 = u_i2cs_slave_model.n_stop;
        u_i2cs_slave_model.wr_q.delete();
        nak_at = 8'h00;
        push(I2CS_OP_START, 0, 0, 0, 8'h00);
        push(I2CS_OP_WRITE, 0, 0, 0, 8'h81);
        push(I2CS_OP_WRITE, 0, 1, 0, 8'h7e);
        push(I2CS_OP_STOP, 1, 0, 0, 8'h00);
        run(1'b1, 8000);
        chk("wr count", u_i2cs_slave_model.wr_q.size(), 1);
        chk("status", status, {2'b10, 8'h01});
        chk("no stop", u_i2cs_slave_model.n_stop - s0, 0);
        nak_at = 8'hff;
    endtask
    task automatic t_busy();
        hold0 = 1'b1;
        push(I2CS_OP_START, 0, 0, 0, 8'h00);
        push(I2CS_OP_STOP, 1, 0, 0, 8'h00);
        run(1'b0, 4000);
        chk("status", status, {2'b11, 8'h00});
        hold0 = 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        run_start = 1'b0;
        run_port = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        hold0 = 1'b0;
        rd_mode = 1'b0;
        rd_base = 8'h50;
        nak_at = 8'hff;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        t_fifo_stop();
        t_write();
        t_read();
        t_nak();
        t_busy();
        chk("port0 idle", p0_act, 0);
        end_sim();
    end
endmodule
